// *** hw/rfmg_pkg.sv ***
// Shared constants of the redundant fieldbus master gateway
package rfmg_pkg;
  // ****************************************************
  // Clock and serial rates
  // ****************************************************
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned FIELD_BAUD     = 38_400;
  localparam int unsigned HOST_BAUD      = 57_600;
  localparam int unsigned PEER_BAUD      = 115_200;
  localparam int unsigned FIELD_DIV      = CLK_HZ / FIELD_BAUD;
  localparam int unsigned HOST_DIV       = CLK_HZ / HOST_BAUD;
  localparam int unsigned PEER_DIV       = CLK_HZ / PEER_BAUD;
  localparam int unsigned UART_BITS      = 11;  // Start, 8 data, even parity, 1 stop
  localparam int unsigned GAP_CHARS      = 4;   // Idle time that ends a frame
  localparam int unsigned RSP_TIMEOUT_US = 5000;
  localparam int unsigned RSP_TIMEOUT_CYC = (CLK_HZ / 1_000_000) * RSP_TIMEOUT_US;
  localparam int unsigned FAIL_LIMIT     = 3;

  // ****************************************************
  // Addressing and frames
  // ****************************************************
  localparam int unsigned MAX_SLAVES   = 247;
  localparam int unsigned VAR1_SLAVES  = 127;
  localparam logic [7:0]  BCAST_ADDR   = 8'h00;
  localparam logic [7:0]  HOST_ADDR_DF = 8'h0a;
  localparam logic [7:0]  FN_POLL      = 8'h01;
  localparam logic [7:0]  FN_WRITE     = 8'h02;
  localparam logic [1:0]  POLL_LEN     = 2'h2;
  localparam logic [1:0]  WRITE_LEN    = 2'h3;
  localparam logic [1:0]  RSP_LEN      = 2'h2;
  localparam int unsigned NCH          = 2;

  typedef enum logic {RFMG_VAR1, RFMG_VAR2} rfmg_variant_e;
endpackage : rfmg_pkg

// *** hw/rfmg_field_if.sv ***
// Two redundant half-duplex field channels between master and actuators
`timescale 1ns/10ps
`default_nettype none
interface rfmg_field_if;
  import rfmg_pkg::*;
  logic [NCH-1:0] m_tx;
  logic [NCH-1:0] m_oe;
  logic [NCH-1:0] s_tx;
  logic [NCH-1:0] s_oe;
  logic [NCH-1:0] line;

  // Idle line reads high, as a biased RS485 pair does
  assign line = (m_oe & m_tx) | (~m_oe & s_oe & s_tx) | (~m_oe & ~s_oe);

  modport master (output m_tx, output m_oe, input line);
  modport slave  (output s_tx, output s_oe, input line);
endinterface : rfmg_field_if
`default_nettype wire

// *** hw/rfmg_uart.sv ***
// 8E1 serial transmitter and receiver on a divided bit enable
`timescale 1ns/10ps
`default_nettype none
module rfmg_uart
  import rfmg_pkg::*;
#(
  parameter int unsigned DIV = FIELD_DIV
)(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Transmit side
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            txd,
  // Receive side
  input  wire logic       rxd,
  output logic [7:0]      rx_data,
  output logic            rx_valid
);
  localparam int unsigned DW = $clog2(DIV + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);
  localparam logic [DW-1:0] DIV_HALF = DW'(DIV / 2);
  localparam logic [3:0]    NBITS    = 4'(UART_BITS);

  logic [10:0]   tx_sh_ff;
  logic [3:0]    tx_left_ff;
  logic [DW-1:0] tx_div_ff;
  logic          rx_s1_ff;
  logic          rx_s2_ff;
  logic [9:0]    rx_sh_ff;
  logic [3:0]    rx_left_ff;
  logic [DW-1:0] rx_div_ff;
  logic          rx_done_ff;
  logic          tx_tick;

  // ****************************************************
  // Transmitter
  // ****************************************************
  assign tx_ready = (tx_left_ff == 4'h0);
  assign txd      = tx_sh_ff[0];
  assign tx_tick  = (tx_div_ff == DIV_LAST);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_sh_ff   <= 11'h7ff;
      tx_left_ff <= 4'h0;
      tx_div_ff  <= '0;
    end
    else if (tx_ready && tx_valid)
    begin
      tx_sh_ff   <= {1'b1, ^tx_data, tx_data, 1'b0};
      tx_left_ff <= NBITS;
      tx_div_ff  <= '0;
    end
    else if (!tx_ready)
    begin
      tx_div_ff <= tx_tick ? '0 : tx_div_ff + 1'b1;
      if (tx_tick)
      begin
        tx_sh_ff   <= {1'b1, tx_sh_ff[10:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
      end
    end
  end

  // ****************************************************
  // Receiver, sampled mid-bit
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
    end
    else
    begin
      rx_s1_ff <= rxd;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sh_ff   <= '0;
      rx_left_ff <= 4'h0;
      rx_div_ff  <= '0;
      rx_done_ff <= 1'b0;
    end
    else
    begin
      rx_done_ff <= 1'b0;
      if (rx_left_ff == 4'h0)
      begin
        if (!rx_s2_ff)
        begin
          rx_left_ff <= NBITS;
          rx_div_ff  <= DIV_HALF;
        end
      end
      else if (rx_div_ff == '0)
      begin
        rx_sh_ff   <= {rx_s2_ff, rx_sh_ff[9:1]};
        rx_left_ff <= rx_left_ff - 4'h1;
        rx_div_ff  <= DIV_LAST;
        rx_done_ff <= (rx_left_ff == 4'h1);
      end
      else
        rx_div_ff <= rx_div_ff - 1'b1;
    end
  end

  // Parity or framing errors drop the byte silently
  assign rx_data  = rx_sh_ff[7:0];
  assign rx_valid = rx_done_ff && rx_sh_ff[9] && !(^rx_sh_ff[8:0]);
endmodule : rfmg_uart
`default_nettype wire

// *** hw/rfmg_gateway.sv ***
// Field master end of the gateway with host request intake and station redundancy
// How it works
// - Up to 247 actuators, addresses 1..247
// - Address zero is broadcast, never one actuator
// - Host slave address defaults to ten
// - One field channel active, switch on fault
// - Both channels share identical bus parameters
// - Command frame only when command data changed
// - Field link 38400 baud, 8E1
// - Primary active; standby listens, never answers
// - Standby takes over when primary unavailable
// - Both stations use same addresses, parameters
// - Station link 115200 baud 8E1 full duplex
// - Variant selects 127 or 247 actuators
// - Host link 57600 baud, 8E1
// - Both host channels accept requests; channel 0 wins a same-cycle clash
// - Host can read each field channel health
// - Ethernet picks 10, 100 or 1000 automatically
`timescale 1ns/10ps
`default_nettype none
module rfmg_gateway
  import rfmg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = RSP_TIMEOUT_CYC,
  parameter logic [7:0]  HOST_ADDR   = HOST_ADDR_DF
)(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Field channels
  rfmg_field_if.master          fld,
  // Configuration
  input  wire logic [7:0]       cfg_num_act,
  input  wire rfmg_variant_e    host_protocol_variant,
  input  wire logic [7:0]       cfg_host_addr,
  input  wire logic             cfg_host_addr_use,
  // Redundancy
  input  wire logic             backup_station,
  input  wire logic             peer_alive,
  output logic                  station_active,
  // Host requests, one group per channel
  input  wire logic [NCH-1:0]   h_req_valid,
  input  wire logic [NCH-1:0][7:0] h_req_addr,
  input  wire logic [NCH-1:0][7:0] h_req_act,
  input  wire logic [NCH-1:0][7:0] h_req_data,
  output logic [NCH-1:0]        h_req_ack,
  // Host status reads
  input  wire logic [7:0]       h_rd_act,
  output logic [7:0]            h_rd_status_ff,
  output logic [NCH-1:0]        field_chan_ok_ff,
  output logic                  field_chan_sel_ff,
  // Ethernet rate choice
  input  wire logic [2:0]       eth_partner_caps,
  output logic [2:0]            eth_rate_sel_ff
);
  typedef enum logic [1:0] {RFMG_IDLE, RFMG_SEND, RFMG_WAIT, RFMG_NEXT} rfmg_state_e;
  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TO_LAST = TW'(TIMEOUT_CYC - 1);
  localparam int unsigned QUIET_CYC = (GAP_CHARS * UART_BITS + 1) * FIELD_DIV;
  localparam int unsigned QW = $clog2(QUIET_CYC + 1);
  localparam logic [QW-1:0] QUIET_LAST = QW'(QUIET_CYC);

  rfmg_state_e state_ff;
  logic [7:0]  cmd_mem  [1:MAX_SLAVES];
  logic [7:0]  sent_mem [1:MAX_SLAVES];
  logic [7:0]  stat_mem [1:MAX_SLAVES];
  logic [7:0]  idx_ff;
  logic [1:0]  pos_ff;
  logic        wr_ff;
  logic [7:0]  rsp0_ff;
  logic [TW-1:0] to_ff;
  logic [1:0]  fail_ff;
  logic [QW-1:0] quiet_ff;
  logic [MAX_SLAVES:1] cmd_vld_ff;
  logic [MAX_SLAVES:1] sent_vld_ff;
  logic        bk_s1_ff;
  logic        bk_s2_ff;
  logic [7:0]  n_act;
  logic [7:0]  host_addr;
  logic [7:0]  tx_byte;
  logic        tx_ready_sel;
  logic        rx_valid_sel;
  logic [7:0]  rx_data_sel;
  logic [NCH-1:0] tx_ready;
  logic [NCH-1:0] rx_valid;
  logic [NCH-1:0][7:0] rx_data;
  logic [NCH-1:0] req_ok;
  logic        tx_go;
  logic        rsp_done;
  logic        timeout;

  function automatic logic [7:0] frame_byte(input logic [1:0] pos, input logic [7:0] addr,
                                            input logic wr, input logic [7:0] data);
    unique case (pos)
      2'h0:    frame_byte = addr;
      2'h1:    frame_byte = wr ? FN_WRITE : FN_POLL;
      default: frame_byte = data;
    endcase
  endfunction : frame_byte

  // ****************************************************
  // Station role
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bk_s1_ff <= 1'b0;
      bk_s2_ff <= 1'b0;
    end
    else
    begin
      bk_s1_ff <= backup_station;
      bk_s2_ff <= bk_s1_ff;
    end
  end

  assign station_active = !bk_s2_ff || !peer_alive;

  // ****************************************************
  // Host request intake
  // ****************************************************
  assign host_addr = cfg_host_addr_use ? cfg_host_addr : HOST_ADDR;
  assign n_act = (host_protocol_variant == RFMG_VAR1 && cfg_num_act > 8'(VAR1_SLAVES)) ?
                 8'(VAR1_SLAVES) : cfg_num_act;

  generate
    for (genvar c = 0; c < NCH; c++)
    begin : g_host
      assign req_ok[c] = h_req_valid[c] && station_active &&
                         (h_req_addr[c] == host_addr || h_req_addr[c] == BCAST_ADDR) &&
                         h_req_act[c] != BCAST_ADDR && h_req_act[c] <= 8'(MAX_SLAVES);
    end
  endgenerate

  // Channel 0 wins a same-cycle clash; channel 1 simply retries
  assign h_req_ack = {req_ok[1] && !req_ok[0], req_ok[0]};

  always_ff @(posedge ref_clk)
  begin
    if (h_req_ack[0])
      cmd_mem[h_req_act[0]] <= h_req_data[0];
    else if (h_req_ack[1])
      cmd_mem[h_req_act[1]] <= h_req_data[1];
  end

  // Memories are not reset, so these bits keep unknown contents out of the change test
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_vld_ff  <= '0;
      sent_vld_ff <= '0;
    end
    else
    begin
      if (|h_req_ack)
        cmd_vld_ff[h_req_ack[0] ? h_req_act[0] : h_req_act[1]] <= 1'b1;
      if (rsp_done && wr_ff)
        sent_vld_ff[idx_ff] <= 1'b1;
    end
  end

  // Silence before each frame lets the actuators' parsers rearm
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      quiet_ff <= QUIET_LAST;
    else if (rx_valid_sel || state_ff == RFMG_SEND)
      quiet_ff <= '0;
    else if (quiet_ff != QUIET_LAST)
      quiet_ff <= quiet_ff + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      h_rd_status_ff <= 8'h00;
    else if (h_rd_act != BCAST_ADDR && h_rd_act <= 8'(MAX_SLAVES))
      h_rd_status_ff <= stat_mem[h_rd_act];
  end

  // ****************************************************
  // Field channels
  // ****************************************************
  generate
    for (genvar c = 0; c < NCH; c++)
    begin : g_fld
      // Same divider on both channels keeps their parameters identical
      rfmg_uart #(.DIV(FIELD_DIV)) u_uart (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .tx_data  (tx_byte),
        .tx_valid (tx_go && field_chan_sel_ff == 1'(c)),
        .tx_ready (tx_ready[c]),
        .txd      (fld.m_tx[c]),
        .rxd      (fld.line[c]),
        .rx_data  (rx_data[c]),
        .rx_valid (rx_valid[c])
      );
      assign fld.m_oe[c] = station_active && state_ff == RFMG_SEND &&
                           field_chan_sel_ff == 1'(c);
    end
  endgenerate

  assign tx_ready_sel = tx_ready[field_chan_sel_ff];
  assign rx_valid_sel = rx_valid[field_chan_sel_ff];
  assign rx_data_sel  = rx_data[field_chan_sel_ff];
  assign tx_byte      = frame_byte(pos_ff, idx_ff, wr_ff, cmd_mem[idx_ff]);
  assign tx_go        = state_ff == RFMG_SEND && tx_ready_sel &&
                        pos_ff != (wr_ff ? WRITE_LEN : POLL_LEN);
  assign rsp_done     = state_ff == RFMG_WAIT && rx_valid_sel && pos_ff == 2'h1 &&
                        rsp0_ff == idx_ff;
  assign timeout      = state_ff == RFMG_WAIT && to_ff == TO_LAST;

  // ****************************************************
  // Polling sequencer
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= RFMG_IDLE;
      idx_ff   <= 8'h01;
      pos_ff   <= 2'h0;
      wr_ff    <= 1'b0;
      rsp0_ff  <= 8'h00;
      to_ff    <= '0;
    end
    else
    begin
      unique case (state_ff)
        RFMG_IDLE:
          if (station_active && n_act != 8'h00 && quiet_ff == QUIET_LAST)
          begin
            wr_ff    <= cmd_vld_ff[idx_ff] && (!sent_vld_ff[idx_ff] ||
                        cmd_mem[idx_ff] != sent_mem[idx_ff]);
            pos_ff   <= 2'h0;
            state_ff <= RFMG_SEND;
          end
        RFMG_SEND:
          if (tx_go)
            pos_ff <= pos_ff + 2'h1;
          else if (tx_ready_sel)
          begin
            pos_ff   <= 2'h0;
            to_ff    <= '0;
            state_ff <= RFMG_WAIT;
          end
        RFMG_WAIT:
        begin
          to_ff <= to_ff + 1'b1;
          if (rsp_done || timeout)
            state_ff <= RFMG_NEXT;
          else if (rx_valid_sel)
          begin
            rsp0_ff <= rx_data_sel;
            pos_ff  <= RSP_LEN - 2'h1;
          end
        end
        RFMG_NEXT:
        begin
          idx_ff   <= (idx_ff >= n_act) ? 8'h01 : idx_ff + 8'h01;
          state_ff <= RFMG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rsp_done)
    begin
      stat_mem[idx_ff] <= rx_data_sel;
      if (wr_ff)
        sent_mem[idx_ff] <= cmd_mem[idx_ff];
    end
  end

  // ****************************************************
  // Channel health and switchover
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fail_ff           <= 2'h0;
      field_chan_sel_ff <= 1'b0;
      field_chan_ok_ff  <= '1;
    end
    else if (rsp_done)
    begin
      fail_ff <= 2'h0;
      field_chan_ok_ff[field_chan_sel_ff] <= 1'b1;
    end
    else if (timeout)
    begin
      if (fail_ff == 2'(FAIL_LIMIT - 1))
      begin
        fail_ff           <= 2'h0;
        field_chan_ok_ff[field_chan_sel_ff] <= 1'b0;
        field_chan_sel_ff <= !field_chan_sel_ff;
      end
      else
        fail_ff <= fail_ff + 2'h1;
    end
  end

  // ****************************************************
  // Ethernet rate choice: fastest shared rate
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      eth_rate_sel_ff <= 3'h1;
    else if (eth_partner_caps[2])
      eth_rate_sel_ff <= 3'h4;
    else if (eth_partner_caps[1])
      eth_rate_sel_ff <= 3'h2;
    else
      eth_rate_sel_ff <= 3'h1;
  end
endmodule : rfmg_gateway
`default_nettype wire

// *** hw/rfmg_actuator.sv ***
// Field actuator end: one slave answering on whichever channel it is asked
`timescale 1ns/10ps
`default_nettype none
module rfmg_actuator
  import rfmg_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Field channels
  rfmg_field_if.slave     fld,
  // Actuator side
  input  wire logic [7:0] my_addr,
  input  wire logic [7:0] my_status,
  output logic [7:0]      cmd_data_ff,
  output logic            cmd_valid_ff
);
  localparam int unsigned GAP_CYC = GAP_CHARS * UART_BITS * FIELD_DIV;
  localparam int unsigned GW = $clog2(GAP_CYC + 1);

  logic [NCH-1:0]      wr_hit;
  logic [NCH-1:0][7:0] wr_val;

  generate
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
      logic [7:0]    rx_data;
      logic          rx_valid;
      logic          tx_ready;
      logic [1:0]    pos_ff;
      logic [7:0]    addr_ff;
      logic          wr_ff;
      logic [1:0]    rsp_ff;
      logic [GW-1:0] gap_ff;
      logic          rsp_go;
      logic          turn;

      rfmg_uart #(.DIV(FIELD_DIV)) u_uart (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .tx_data  (rsp_ff == RSP_LEN ? my_addr : my_status),
        .tx_valid (rsp_go),
        .tx_ready (tx_ready),
        .txd      (fld.s_tx[c]),
        .rxd      (fld.line[c]),
        .rx_data  (rx_data),
        .rx_valid (rx_valid)
      );

      // Hold the reply one bit time so the master has released the line
      assign turn        = gap_ff >= GW'(FIELD_DIV);
      assign rsp_go      = rsp_ff != 2'h0 && tx_ready && turn;
      assign fld.s_oe[c] = !tx_ready || (rsp_ff != 2'h0 && turn);
      // Broadcast writes are applied but never answered
      assign wr_hit[c] = rx_valid && pos_ff == 2'h2 && wr_ff &&
                         (addr_ff == my_addr || addr_ff == BCAST_ADDR);
      assign wr_val[c] = rx_data;

      // ****************************************************
      // Frame parser, reset by line silence
      // ****************************************************
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pos_ff  <= 2'h0;
          addr_ff <= 8'h00;
          wr_ff   <= 1'b0;
          rsp_ff  <= 2'h0;
          gap_ff  <= '0;
        end
        else
        begin
          gap_ff <= rx_valid ? '0 : (gap_ff == GW'(GAP_CYC) ? gap_ff : gap_ff + 1'b1);
          if (rsp_go)
            rsp_ff <= rsp_ff - 2'h1;
          if (rx_valid)
          begin
            unique case (pos_ff)
              2'h0:
              begin
                addr_ff <= rx_data;
                pos_ff  <= 2'h1;
              end
              2'h1:
              begin
                wr_ff  <= rx_data == FN_WRITE;
                pos_ff <= (rx_data == FN_WRITE) ? 2'h2 : 2'h3;
                if (rx_data == FN_POLL && addr_ff == my_addr && my_addr != BCAST_ADDR)
                  rsp_ff <= RSP_LEN;
              end
              2'h2:
              begin
                pos_ff <= 2'h3;
                if (addr_ff == my_addr && my_addr != BCAST_ADDR)
                  rsp_ff <= RSP_LEN;
              end
              default: ;
            endcase
          end
          else if (gap_ff == GW'(GAP_CYC))
            pos_ff <= 2'h0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_data_ff  <= 8'h00;
      cmd_valid_ff <= 1'b0;
    end
    else
    begin
      cmd_valid_ff <= |wr_hit;
      if (wr_hit[0])
        cmd_data_ff <= wr_val[0];
      else if (wr_hit[1])
        cmd_data_ff <= wr_val[1];
    end
  end
endmodule : rfmg_actuator
`default_nettype wire

// *** test/rfmg_monitor.sv ***
// Concurrent checks on the field channels between gateway and actuator
`timescale 1ns/10ps
`default_nettype none
module rfmg_monitor
  import rfmg_pkg::*;
(
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  // Field channels
  input  wire logic [NCH-1:0] m_tx,
  input  wire logic [NCH-1:0] m_oe,
  input  wire logic [NCH-1:0] s_tx,
  input  wire logic [NCH-1:0] s_oe,
  input  wire logic [NCH-1:0] line
);
  // ******************************
  // Run length of channel A level
  // ******************************
  // Margin of a few cycles keeps the length checks clear of edge alignment
  localparam int BIT_MIN = FIELD_DIV - 4;
  localparam int LOW_MAX = 10 * FIELD_DIV + 4;
  logic        prev_ff;
  logic [15:0] run_ff;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_ff <= 1'b1;
      run_ff  <= 16'h0;
    end
    else
    begin
      prev_ff <= line[0];
      run_ff  <= (line[0] != prev_ff) ? 16'h0 : run_ff + {15'h0, ~&run_ff};
    end
  end

  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_one_master_chan: assert property (!(m_oe[0] && m_oe[1]))
    else $error("master drives both channels");
  a_no_bus_clash: assert property ((m_oe & s_oe) == 2'h0)
    else $error("master and actuator drive one channel");
  a_one_slave_chan: assert property (!(s_oe[0] && s_oe[1]))
    else $error("actuator drives both channels");
  a_master_idle_high: assert property ((m_tx | m_oe) == 2'h3)
    else $error("master line not idle high");
  a_slave_idle_high: assert property ((s_tx | s_oe) == 2'h3)
    else $error("actuator line not idle high");
  a_start_bit_low: assert property ($rose(m_oe[0]) |-> ##[0:2] !m_tx[0])
    else $error("no start bit after drive begins");
  a_bit_len_min: assert property (line[0] && !prev_ff && m_oe[0] |-> run_ff >= BIT_MIN)
    else $error("low level shorter than one bit");
  a_low_run_max: assert property (!line[0] && m_oe[0] |-> run_ff <= LOW_MAX)
    else $error("low level longer than start, data and parity");
  a_slave_after_master: assert property ($rose(s_oe[0]) |-> !m_oe[0] && !$past(m_oe[0]))
    else $error("actuator drives before master released");
endmodule : rfmg_monitor
`default_nettype wire

// *** test/tb.sv ***
// Bench for the gateway and one actuator sharing the field channels
`timescale 1ns/10ps
`default_nettype none
module tb
  import rfmg_pkg::*;
;
  // ******************************
  // Signals and instances
  // ******************************
  logic                ref_clk;
  logic                rst_n;
  logic [7:0]          cfg_num_act, cfg_host_addr, h_rd_act, my_addr, my_status, d;
  logic                cfg_host_addr_use, backup_station, peer_alive, station_active;
  rfmg_variant_e       host_protocol_variant;
  logic [NCH-1:0]      h_req_valid, h_req_ack, field_chan_ok_ff;
  logic [NCH-1:0][7:0] h_req_addr, h_req_act, h_req_data;
  logic [7:0]          h_rd_status_ff, cmd_data_ff;
  logic                field_chan_sel_ff, cmd_valid_ff;
  logic [2:0]          eth_partner_caps, eth_rate_sel_ff;
  int                  bad_count, tests_run;
  logic [7:0]          exp_q[$];

  rfmg_field_if fld_if ();
  // Short reply timeout keeps a lost reply from stalling the run
  rfmg_gateway #(.TIMEOUT_CYC(40000)) i_rfmg_gateway (.ref_clk, .rst_n, .fld(fld_if),
    .cfg_num_act, .host_protocol_variant, .cfg_host_addr, .cfg_host_addr_use,
    .backup_station, .peer_alive, .station_active, .h_req_valid, .h_req_addr, .h_req_act,
    .h_req_data, .h_req_ack, .h_rd_act, .h_rd_status_ff, .field_chan_ok_ff,
    .field_chan_sel_ff, .eth_partner_caps, .eth_rate_sel_ff);
  rfmg_actuator i_rfmg_actuator (.ref_clk, .rst_n, .fld(fld_if), .my_addr, .my_status,
    .cmd_data_ff, .cmd_valid_ff);
  rfmg_monitor i_rfmg_monitor (.ref_clk, .rst_n, .m_tx(fld_if.m_tx), .m_oe(fld_if.m_oe),
    .s_tx(fld_if.s_tx), .s_oe(fld_if.s_oe), .line(fld_if.line));

  // ******************************
  // Tasks
  // ******************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic req(input logic [1:0] v, input logic [7:0] a, input logic [7:0] act,
                     input logic [1:0] ack);
    @(negedge ref_clk);
    h_req_addr  = {a, a};
    h_req_act   = {act, act};
    h_req_data  = {d, d};
    h_req_valid = v;
    #1;
    chk({6'h0, h_req_ack}, {6'h0, ack});
    @(negedge ref_clk);
    h_req_valid = 2'h0;
  endtask : req

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // ******************************
  // Clock, result watcher, watchdog
  // ******************************
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Any command pulse with no note queued is a mismatch
  always @(negedge ref_clk)
    if (cmd_valid_ff === 1'b1)
      chk(cmd_data_ff, (exp_q.size() > 0) ? exp_q.pop_front() : ~cmd_data_ff);

  initial
  begin
    repeat (99000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end

  // ******************************
  // Tests
  // ******************************
  initial
  begin
    rst_n = 1'b0;
    cfg_num_act = 8'h00;
    cfg_host_addr = 8'h00;
    cfg_host_addr_use = 1'b0;
    host_protocol_variant = RFMG_VAR2;
    backup_station = 1'b0;
    peer_alive = 1'b1;
    h_req_valid = 2'h0;
    h_req_addr = '0;
    h_req_act = '0;
    h_req_data = '0;
    h_rd_act = 8'h01;
    my_addr = 8'h01;
    my_status = 8'h00;
    eth_partner_caps = 3'h0;
    d = 8'h00;
    void'($urandom(43));
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge ref_clk);
      eth_partner_caps = 3'(i);
      @(negedge ref_clk);
      chk({5'h0, eth_rate_sel_ff}, i[2] ? 8'h04 : i[1] ? 8'h02 : 8'h01);
    end
    $display("ethernet rate test done");
    d = 8'($urandom);
    req(2'h1, 8'h0a, 8'h01, 2'h1);
    req(2'h2, 8'h0a, 8'hf7, 2'h2);
    req(2'h3, 8'h00, 8'h02, 2'h1);
    req(2'h1, 8'h0b, 8'h01, 2'h0);
    req(2'h1, 8'h0a, 8'h00, 2'h0);
    req(2'h2, 8'h0a, 8'hf8, 2'h0);
    cfg_host_addr = 8'($urandom_range(247, 11));
    cfg_host_addr_use = 1'b1;
    req(2'h1, cfg_host_addr, 8'h03, 2'h1);
    req(2'h1, 8'h0a, 8'h03, 2'h0);
    cfg_host_addr_use = 1'b0;
    $display("host request test done");
    backup_station = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({7'h0, station_active}, 8'h00);
    req(2'h1, 8'h0a, 8'h01, 2'h0);
    peer_alive = 1'b0;
    #1;
    chk({7'h0, station_active}, 8'h01);
    req(2'h1, 8'h0a, 8'h01, 2'h1);
    backup_station = 1'b0;
    $display("standby test done");
    d = 8'($urandom);
    my_status = 8'($urandom_range(255, 1));
    exp_q.push_back(d);
    req(2'h1, 8'h0a, 8'h01, 2'h1);
    cfg_num_act = 8'h01;
    for (int n = 0; n < 60000 && exp_q.size() > 0; n++)
      @(negedge ref_clk);
    chk(8'(exp_q.size()), 8'h00);
    for (int n = 0; n < 40000 && h_rd_status_ff !== my_status; n++)
      @(negedge ref_clk);
    chk(h_rd_status_ff, my_status);
    chk({6'h0, field_chan_ok_ff}, 8'h03);
    chk({7'h0, field_chan_sel_ff}, 8'h00);
    $display("field transfer test done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
